// File: pkg/eeelpi_regs.vh
`ifndef EEELPI_REGS_VH
`define EEELPI_REGS_VH

// register byte offsets
`define EEELPI_ADDR_W        12
`define EEELPI_OFF_CTRLSTAT  12'h000
`define EEELPI_OFF_TIMERS    12'h004
`define EEELPI_OFF_CONFIG    12'h008

// control/status fields
`define EEELPI_TX_ENTRY_BIT  0
`define EEELPI_TX_EXIT_BIT   1
`define EEELPI_RX_ENTRY_BIT  2
`define EEELPI_RX_EXIT_BIT   3
`define EEELPI_TX_STATE_BIT  8
`define EEELPI_RX_STATE_BIT  9
`define EEELPI_TX_EN_BIT     16
`define EEELPI_LINK_UP_BIT   17
`define EEELPI_AUTO_BIT      19

// timers fields
`define EEELPI_WAKE_LSB      0
`define EEELPI_WAKE_W        16
`define EEELPI_LINKUP_LSB    16
`define EEELPI_LINKUP_W      10

// config fields
`define EEELPI_FDX_BIT       0
`define EEELPI_MII_BIT       1
`define EEELPI_SRST_BIT      2

// reset values
`define EEELPI_CTRL_RST      32'h0000_0000
`define EEELPI_WAKE_RST      16'h0000
`define EEELPI_LINKUP_RST    10'h3e8
`define EEELPI_CFG_RST       2'h0

// mii low-power idle pattern
`define EEELPI_LPI_TXD       4'h1
`define EEELPI_LPI_RXD       4'h1

// timing
`define EEELPI_CLK_MHZ       125
`define EEELPI_TICK_US       1
`define EEELPI_US_CYC        (`EEELPI_TICK_US * `EEELPI_CLK_MHZ)
`define EEELPI_US_PER_MS     1000

`endif

// File: src/eeelpi_ctrl.v
`timescale 1ns/10ps
`include "eeelpi_regs.vh"
// Behaviour
// - tx low-power idle only when full duplex and MII mode are both configured; rx LPI detection checks neither
// - enable bit requests LPI; frame in progress finishes first, then pattern
// - LPI pattern: tx_en low, tx_er high, txd 0x1
// - pattern held unchanged for the whole low-power period
// - entering tx LPI sets status bit0 and raises interrupt
// - clearing enable with auto entry off returns to normal idle and starts wake timer
// - no frame starts until wake timer expires; wake time in timers [15:0]
// - leaving tx LPI sets status bit1 and raises interrupt
// - soft or hard reset returns transmitter to normal operation
// - rx LPI detection sets status bit2 and raises interrupt
// - rx LPI exit sets bit3, raises interrupt and pulses low-power output
// - reset leaves rx LPI; pattern still present re-enters it
// - 10-bit millisecond link-up timer cleared on link down gates LPI
// - 16-bit microsecond wake timer from LPI exit, terminal count programmed
// - link-up flag at 0 resets the internal low-power timers
module eeelpi_ctrl (
	input  wire                      i_sys_clk,
	input  wire                      i_rstn,
	input  wire                      i_psel,
	input  wire                      i_penable,
	input  wire                      i_pwrite,
	input  wire [`EEELPI_ADDR_W-1:0] i_paddr,
	input  wire [31:0]               i_pwdata,
	output reg  [31:0]               o_prdata,
	output reg                       o_pready,
	output reg                       o_pslverr,
	input  wire                      i_mac_tx_busy,
	input  wire                      i_mac_tx_en,
	input  wire                      i_mac_tx_er,
	input  wire [3:0]                i_mac_txd,
	output reg                       o_tx_hold,
	input  wire                      i_mii_tx_clk,
	output reg                       o_mii_tx_en,
	output reg                       o_mii_tx_er,
	output reg  [3:0]                o_mii_txd,
	input  wire                      i_mii_rx_clk,
	input  wire                      i_mii_rx_dv,
	input  wire                      i_mii_rx_er,
	input  wire [3:0]                i_mii_rxd,
	output reg                       o_lpi_irq,
	output reg                       o_lowpower_irq_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LPI  = 2'h1;
	localparam ST_WAKE = 2'h2;

	reg [1:0]                  state_r;
	reg [1:0]                  state_nxt;
	reg [3:0]                  flags_r;
	reg                        tx_lowpower_enable_r;
	reg                        phy_link_up_flag_r;
	reg                        tx_lowpower_auto_entry_r;
	reg [`EEELPI_WAKE_W-1:0]   wake_time_count_r;
	reg [`EEELPI_LINKUP_W-1:0] link_up_delay_r;
	reg                        fdx_r;
	reg                        mii_r;
	reg                        srst_r;
	reg [`EEELPI_LINKUP_W-1:0] link_up_delay_timer_r;
	reg [`EEELPI_WAKE_W-1:0]   wake_time_timer_r;
	reg                        rx_lpi_r;
	reg                        txclk_d_r;
	reg                        rxclk_d_r;

	wire       txclk_s;
	wire [6:0] rx_s;
	wire       us_tick;
	wire       ms_tick;

	function [31:0] place_bit;
		input integer pos;
		begin
			place_bit = 32'h0000_0001 << pos;
		end
	endfunction

	eeelpi_sync #(.W(1)) u_txclk_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_d       (i_mii_tx_clk),
		.o_q       (txclk_s)
	);

	eeelpi_sync #(.W(7)) u_rx_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_d       ({i_mii_rx_clk, i_mii_rx_dv, i_mii_rx_er, i_mii_rxd}),
		.o_q       (rx_s)
	);

	eeelpi_tick u_tick (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_clr     (srst_r),
		.o_us_tick (us_tick),
		.o_ms_tick (ms_tick)
	);

	// apb decode
	wire setup    = i_psel & ~i_penable;
	wire wr_acc   = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
	wire hit_cs   = (i_paddr == `EEELPI_OFF_CTRLSTAT);
	wire hit_tm   = (i_paddr == `EEELPI_OFF_TIMERS);
	wire hit_cfg  = (i_paddr == `EEELPI_OFF_CONFIG);
	wire wr_cs    = wr_acc & hit_cs;
	wire wr_tm    = wr_acc & hit_tm;
	wire wr_cfg   = wr_acc & hit_cfg;

	wire lpi_allowed = fdx_r & mii_r;
	wire link_done   = phy_link_up_flag_r & (link_up_delay_timer_r >= link_up_delay_r);
	wire lpi_req     = tx_lowpower_enable_r | (tx_lowpower_auto_entry_r & ~i_mac_tx_busy);
	wire tx_fall     = txclk_d_r & ~txclk_s;
	wire rx_rise     = rx_s[6] & ~rxclk_d_r;
	wire rx_pattern  = rx_s[4] & ~rx_s[5] & (rx_s[3:0] == `EEELPI_LPI_RXD);
	wire tx_entry    = (state_r != ST_LPI) & (state_nxt == ST_LPI);
	wire tx_exit     = (state_r == ST_LPI) & (state_nxt != ST_LPI);
	wire rx_entry    = rx_rise & rx_pattern & ~rx_lpi_r;
	wire rx_exit     = rx_rise & ~rx_s[4] & rx_lpi_r;

	wire [3:0] flag_set = {rx_exit, rx_entry, tx_exit, tx_entry};

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				// the frame in flight is let finish before entry
				if (lpi_req & lpi_allowed & link_done & ~i_mac_tx_busy) begin
					state_nxt = ST_LPI;
				end
			end
			ST_LPI: begin
				if (~lpi_req | ~lpi_allowed | ~phy_link_up_flag_r) begin
					state_nxt = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wake_time_timer_r >= wake_time_count_r) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r   <= ST_IDLE;
			o_tx_hold <= 1'b0;
		end else if (srst_r) begin
			state_r   <= ST_IDLE;
			o_tx_hold <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			o_tx_hold <= (state_nxt != ST_IDLE);
		end
	end

	// link-up and wake timers
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			link_up_delay_timer_r <= {`EEELPI_LINKUP_W{1'b0}};
			wake_time_timer_r     <= {`EEELPI_WAKE_W{1'b0}};
		end else if (srst_r | ~phy_link_up_flag_r) begin
			link_up_delay_timer_r <= {`EEELPI_LINKUP_W{1'b0}};
			wake_time_timer_r     <= {`EEELPI_WAKE_W{1'b0}};
		end else begin
			if (ms_tick & (link_up_delay_timer_r < link_up_delay_r)) begin
				link_up_delay_timer_r <= link_up_delay_timer_r + 1'b1;
			end
			if (tx_exit) begin
				wake_time_timer_r <= {`EEELPI_WAKE_W{1'b0}};
			end else if (us_tick & (state_r == ST_WAKE) &
			             (wake_time_timer_r != {`EEELPI_WAKE_W{1'b1}})) begin
				wake_time_timer_r <= wake_time_timer_r + 1'b1;
			end
		end
	end

	// tx pins change only after a falling tx clock edge, so the phy samples stable levels
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			txclk_d_r   <= 1'b0;
			o_mii_tx_en <= 1'b0;
			o_mii_tx_er <= 1'b0;
			o_mii_txd   <= 4'h0;
		end else begin
			txclk_d_r <= txclk_s;
			if (tx_fall) begin
				if (state_r == ST_LPI) begin
					o_mii_tx_en <= 1'b0;
					o_mii_tx_er <= 1'b1;
					o_mii_txd   <= `EEELPI_LPI_TXD;
				end else if (state_r == ST_WAKE) begin
					o_mii_tx_en <= 1'b0;
					o_mii_tx_er <= 1'b0;
					o_mii_txd   <= 4'h0;
				end else begin
					o_mii_tx_en <= i_mac_tx_en;
					o_mii_tx_er <= i_mac_tx_er;
					o_mii_txd   <= i_mac_txd;
				end
			end
		end
	end

	// receive side; entry and exit are only detected on rising rx clock edges, so a stopped clock freezes rx detection
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rxclk_d_r          <= 1'b0;
			rx_lpi_r           <= 1'b0;
			o_lowpower_irq_out <= 1'b0;
		end else begin
			rxclk_d_r          <= rx_s[6];
			o_lowpower_irq_out <= rx_exit & ~srst_r;
			if (srst_r) begin
				rx_lpi_r <= 1'b0;
			end else if (rx_entry) begin
				rx_lpi_r <= 1'b1;
			end else if (rx_exit) begin
				rx_lpi_r <= 1'b0;
			end
		end
	end

	// registers; status flags are write-one-to-clear and a same-cycle event wins
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			flags_r                  <= 4'h0;
			tx_lowpower_enable_r     <= 1'b0;
			phy_link_up_flag_r       <= 1'b0;
			tx_lowpower_auto_entry_r <= 1'b0;
			wake_time_count_r        <= `EEELPI_WAKE_RST;
			link_up_delay_r          <= `EEELPI_LINKUP_RST;
			fdx_r                    <= 1'b0;
			mii_r                    <= 1'b0;
			srst_r                   <= 1'b0;
			o_lpi_irq                <= 1'b0;
		end else begin
			srst_r <= wr_cfg & i_pwdata[`EEELPI_SRST_BIT];
			flags_r <= (flags_r & ~(wr_cs ? i_pwdata[3:0] : 4'h0)) |
			           (srst_r ? 4'h0 : flag_set);
			o_lpi_irq <= |flags_r;
			if (wr_cs) begin
				tx_lowpower_enable_r     <= i_pwdata[`EEELPI_TX_EN_BIT];
				phy_link_up_flag_r       <= i_pwdata[`EEELPI_LINK_UP_BIT];
				tx_lowpower_auto_entry_r <= i_pwdata[`EEELPI_AUTO_BIT];
			end
			if (wr_tm) begin
				wake_time_count_r <= i_pwdata[`EEELPI_WAKE_LSB +: `EEELPI_WAKE_W];
				link_up_delay_r   <= i_pwdata[`EEELPI_LINKUP_LSB +: `EEELPI_LINKUP_W];
			end
			if (wr_cfg) begin
				fdx_r <= i_pwdata[`EEELPI_FDX_BIT];
				mii_r <= i_pwdata[`EEELPI_MII_BIT];
			end
		end
	end

	// apb answer: one access cycle, read data captured in the setup cycle
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup & ~(hit_cs | hit_tm | hit_cfg);
			if (setup & ~i_pwrite) begin
				o_prdata <= 32'h0000_0000;
				if (hit_cs) begin
					o_prdata <= {28'h0000000, flags_r}
					          | ((state_r == ST_LPI) ? place_bit(`EEELPI_TX_STATE_BIT) : 32'h0)
					          | (rx_lpi_r ? place_bit(`EEELPI_RX_STATE_BIT) : 32'h0)
					          | (tx_lowpower_enable_r ? place_bit(`EEELPI_TX_EN_BIT) : 32'h0)
					          | (phy_link_up_flag_r ? place_bit(`EEELPI_LINK_UP_BIT) : 32'h0)
					          | (tx_lowpower_auto_entry_r ? place_bit(`EEELPI_AUTO_BIT) : 32'h0);
				end else if (hit_tm) begin
					o_prdata <= {6'h00, link_up_delay_r, wake_time_count_r};
				end else if (hit_cfg) begin
					o_prdata <= {30'h00000000, mii_r, fdx_r};
				end
			end
		end
	end
endmodule

// File: src/eeelpi_sync.v
`timescale 1ns/10ps
// three-stage synchroniser; a change is accepted once stages two and three agree
module eeelpi_sync #(
	parameter W = 1
) (
	input  wire         i_sys_clk,
	input  wire         i_rstn,
	input  wire [W-1:0] i_d,
	output reg  [W-1:0] o_q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			o_q  <= {W{1'b0}};
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				o_q <= s3_r;
			end
		end
	end
endmodule

// File: src/eeelpi_tick.v
`timescale 1ns/10ps
`include "eeelpi_regs.vh"
// microsecond and millisecond enable pulses from the system clock
module eeelpi_tick #(
	parameter US_CYC    = `EEELPI_US_CYC,
	parameter US_PER_MS = `EEELPI_US_PER_MS
) (
	input  wire i_sys_clk,
	input  wire i_rstn,
	input  wire i_clr,
	output reg  o_us_tick,
	output reg  o_ms_tick
);
	reg [7:0] cyc_r;
	reg [9:0] us_r;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cyc_r     <= 8'h00;
			us_r      <= 10'h000;
			o_us_tick <= 1'b0;
			o_ms_tick <= 1'b0;
		end else if (i_clr) begin
			cyc_r     <= 8'h00;
			us_r      <= 10'h000;
			o_us_tick <= 1'b0;
			o_ms_tick <= 1'b0;
		end else begin
			o_us_tick <= 1'b0;
			o_ms_tick <= 1'b0;
			if (cyc_r == US_CYC[7:0] - 8'h01) begin
				cyc_r     <= 8'h00;
				o_us_tick <= 1'b1;
				if (us_r == US_PER_MS[9:0] - 10'h001) begin
					us_r      <= 10'h000;
					o_ms_tick <= 1'b1;
				end else begin
					us_r <= us_r + 10'h001;
				end
			end else begin
				cyc_r <= cyc_r + 8'h01;
			end
		end
	end
endmodule

// File: test/eeelpi_ctrl_sva.sv
`timescale 1ns/10ps
module eeelpi_ctrl_sva (
	input wire       i_sys_clk,
	input wire       i_rstn,
	input wire       i_psel,
	input wire       i_penable,
	input wire       o_pready,
	input wire       o_pslverr,
	input wire       o_tx_hold,
	input wire       o_mii_tx_en,
	input wire       o_mii_tx_er,
	input wire [3:0] o_mii_txd,
	input wire       i_mii_rx_dv,
	input wire       i_mii_rx_er,
	input wire [3:0] i_mii_rxd,
	input wire       o_lpi_irq,
	input wire       o_lowpower_irq_out
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	wire tx_pat = o_mii_tx_er && !o_mii_tx_en;
	wire rx_pat = i_mii_rx_er && !i_mii_rx_dv && i_mii_rxd == 4'h1;
	a_ready_next: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready too long");
	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_entry_pattern: assert property ($rose(o_tx_hold) |-> ##[1:30] tx_pat && o_mii_txd == 4'h1)
		else $error("no idle pattern after entry");
	a_entry_irq: assert property ($rose(o_tx_hold) |-> ##[0:2] o_lpi_irq)
		else $error("no irq at entry");
	a_pattern_steady: assert property (o_tx_hold && tx_pat |=> !o_mii_tx_er || !o_mii_tx_en && $stable(o_mii_txd))
		else $error("pattern moved");
	a_exit_irq: assert property ($fell(o_mii_tx_er) && o_tx_hold |-> o_lpi_irq)
		else $error("no irq at exit");
	a_rx_entry: assert property ($rose(i_mii_rx_er) ##1 rx_pat [*8] |-> ##[0:30] o_lpi_irq)
		else $error("no irq at rx entry");
	a_rx_exit: assert property ($fell(i_mii_rx_er) && $past(i_mii_rxd) == 4'h1 |-> ##[1:40] o_lowpower_irq_out)
		else $error("no pulse at rx exit");
	a_pulse_once: assert property (o_lowpower_irq_out |=> !o_lowpower_irq_out)
		else $error("pulse too long");
endmodule
bind eeelpi_ctrl eeelpi_ctrl_sva chk_i (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_tx_hold(o_tx_hold), .o_mii_tx_en(o_mii_tx_en),
	.o_mii_tx_er(o_mii_tx_er), .o_mii_txd(o_mii_txd), .i_mii_rx_dv(i_mii_rx_dv),
	.i_mii_rx_er(i_mii_rx_er), .i_mii_rxd(i_mii_rxd), .o_lpi_irq(o_lpi_irq),
	.o_lowpower_irq_out(o_lowpower_irq_out)
);

// File: test/eeelpi_phy_model.sv
`timescale 1ns/10ps
module eeelpi_phy_model (
	input  wire       i_lpi,
	output reg        o_tx_clk = 1'b0,
	output reg        o_rx_clk = 1'b0,
	output wire       o_rx_dv,
	output reg        o_rx_er = 1'b0,
	output reg  [3:0] o_rxd = 4'h0
);
	reg     run = 1'b1;
	integer n = 0;
	assign o_rx_dv = 1'b0;
	// tx clock may not stop in mii mode
	always #40 o_tx_clk = ~o_tx_clk;
	always #40 o_rx_clk = run & ~o_rx_clk;
	always @(i_lpi) if (!i_lpi) run = 1'b1;
	always @(negedge o_rx_clk) begin
		n <= o_rx_er ? n + 1 : 0;
		if (i_lpi) begin
			o_rx_er <= 1'b1;
			o_rxd <= 4'h1;
		end else begin
			o_rx_er <= 1'b0;
			// idle nibble is meaningless, so keep it moving
			o_rxd <= o_rxd + 4'h3;
		end
		if (n == 12 && i_lpi)
			run = 1'b0;
	end
endmodule

// File: test/test_eee_low_power_idle_ctrl.sv
`timescale 1ns/10ps
`include "eeelpi_regs.vh"
module test_eee_low_power_idle_ctrl;
	localparam [11:0] CS = `EEELPI_OFF_CTRLSTAT, TM = `EEELPI_OFF_TIMERS, CF = `EEELPI_OFF_CONFIG;
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        busy = 0, m_en = 0, lpi = 0, err;
	logic [3:0]  m_txd = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, q, seed = 32'h5ac08264;
	integer      n_mismatch = 0, n_tests = 0, t, w;
	wire  [31:0] prdata;
	wire         pready, pslverr, hold, tx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er, irq, lp_irq;
	wire  [3:0]  txd, rxd;
	wire  [31:0] pins = {26'h0, tx_en, tx_er, txd};
	wire  [31:0] st = {29'h0, hold, irq, lp_irq};
	always #4 clk = ~clk;
	eeelpi_ctrl dut (
		.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_mac_tx_busy(busy), .i_mac_tx_en(m_en), .i_mac_tx_er(1'b0),
		.i_mac_txd(m_txd), .o_tx_hold(hold), .i_mii_tx_clk(tx_clk), .o_mii_tx_en(tx_en),
		.o_mii_tx_er(tx_er), .o_mii_txd(txd), .i_mii_rx_clk(rx_clk), .i_mii_rx_dv(rx_dv),
		.i_mii_rx_er(rx_er), .i_mii_rxd(rxd), .o_lpi_irq(irq), .o_lowpower_irq_out(lp_irq)
	);
	eeelpi_phy_model phy (
		.i_lpi(lpi), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk), .o_rx_dv(rx_dv), .o_rx_er(rx_er),
		.o_rxd(rxd)
	);
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			n_mismatch++;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0);
		chk(q, want);
	endtask
	task automatic wait_st(input logic [31:0] mask, input logic [31:0] v);
		t = 0;
		while ((st & mask) !== v && t < 2000) begin
			@(posedge clk);
			t++;
		end
	endtask
	initial begin
		#400000;
		n_mismatch++;
		close_out;
	end
	initial begin
		cyc(16);
		rstn <= 1'b1;
		rd(CS, 32'h0);
		rd(TM, 32'h03e8_0000);
		rd(CF, 32'h0);
		rd(12'h00c, 32'h0);
		chk({31'h0, err}, 32'h1);
		seed = nxt(seed);
		w = seed[1:0] + 1;
		apb(1'b1, TM, w);
		apb(1'b1, CS, 32'h0003_0000);
		cyc(50);
		chk(st, 32'h0);
		apb(1'b1, TM, 32'h0001_0000 | w);
		apb(1'b1, CF, 32'h3);
		// mac idle here, so only the unexpired link-up delay keeps lpi off
		cyc(300);
		chk(st, 32'h0);
		busy <= 1'b1;
		apb(1'b1, TM, w);
		cyc(50);
		chk(st, 32'h0);
		busy <= 1'b0;
		wait_st(4, 4);
		cyc(30);
		chk(pins, 32'h11);
		chk(st, 32'h6);
		rd(CS, 32'h0003_0101);
		apb(1'b1, CS, 32'h0003_0001);
		rd(CS, 32'h0003_0100);
		apb(1'b1, CS, 32'h0002_0000);
		cyc(30);
		chk({pins[15:0], st[15:0]}, 32'h6);
		wait_st(4, 0);
		chk({31'h0, t + 30 > (w - 1) * 125 && t + 30 <= w * 125 + 20}, 32'h1);
		rd(CS, 32'h0002_0002);
		apb(1'b1, CS, 32'h0002_0002);
		repeat (4) begin
			seed = nxt(seed);
			m_en <= seed[4];
			m_txd <= seed[3:0];
			cyc(30);
			chk(pins, {26'h0, seed[4], 1'b0, seed[3:0]});
		end
		m_en <= 1'b0;
		m_txd <= 4'h0;
		lpi <= 1'b1;
		cyc(30);
		rd(CS, 32'h0002_0204);
		apb(1'b1, CS, 32'h0002_0004);
		apb(1'b1, CF, 32'h7);
		cyc(40);
		rd(CS, 32'h0002_0204);
		cyc(400);
		rd(CS, 32'h0002_0204);
		// no register here lives in the rx clock domain, so this write is safe
		apb(1'b1, CS, 32'h0002_0004);
		lpi <= 1'b0;
		wait_st(1, 1);
		chk(st & 32'h1, 32'h1);
		rd(CS, 32'h0002_0008);
		apb(1'b1, CS, 32'h0003_0008);
		wait_st(4, 4);
		cyc(30);
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
		cyc(30);
		chk({pins[15:0], st[15:0]}, 32'h0);
		close_out;
	end
endmodule
